/* File: rtl/sbp_pkg.sv */
// How it works
// - Six pins, direction one means input
// - Input-only pin never drives, reads one
// - Data read shows pins, write hits latch
// - Data write without low lane strobe is read-modify-write into latch
// - Direction still gates drivers on analog pins
// - Analog pins read zero digitally
// - Open-drain bit allows sinking only
// - Slew bit limits output edge rate
// - Threshold bit picks Schmitt or TTL
// - Analog select forces digital reads zero
// - Analog select leaves digital output alone
// - Analog select bits reset to analog
package sbp_pkg;
    // Port geometry
    localparam int        NPIN    = 6;
    localparam int        IN_ONLY = 3;
    localparam int        AW      = 5;
    // Register byte offsets
    localparam logic [AW-1:0] OFF_DATA = 5'h00;
    localparam logic [AW-1:0] OFF_LAT  = 5'h04;
    localparam logic [AW-1:0] OFF_DIR  = 5'h08;
    localparam logic [AW-1:0] OFF_OD   = 5'h0c;
    localparam logic [AW-1:0] OFF_SLEW = 5'h10;
    localparam logic [AW-1:0] OFF_THR  = 5'h14;
    localparam logic [AW-1:0] OFF_ANA  = 5'h18;
    // Reset values
    localparam logic [NPIN-1:0] RST_DIR  = 6'h3f;
    localparam logic [NPIN-1:0] RST_ANA  = 6'h3f;
    localparam logic [NPIN-1:0] RST_LAT  = 6'h00;
    localparam logic [NPIN-1:0] RST_OD   = 6'h00;
    localparam logic [NPIN-1:0] RST_SLEW = 6'h00;
    localparam logic [NPIN-1:0] RST_THR  = 6'h00;
    // Bit that is forced input
    localparam logic [NPIN-1:0] IN_ONLY_MASK = 6'h08;
    // Upper read bits
    localparam logic [31-NPIN:0] RD_PAD = 26'h0;
endpackage

/* File: rtl/sbp_port.sv */
// Decided for this implementation: the placing of the registers and the APB slave port.
module sbp_port (
    input  wire logic                     clk,
    input  wire logic                     srst,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [sbp_pkg::AW-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Pad side
    input  wire logic [sbp_pkg::NPIN-1:0] pin_in,
    output logic      [sbp_pkg::NPIN-1:0] pin_out,
    output logic      [sbp_pkg::NPIN-1:0] pin_oe,
    output logic      [sbp_pkg::NPIN-1:0] slew_limit_select,
    output logic      [sbp_pkg::NPIN-1:0] input_threshold_select,
    output logic      [sbp_pkg::NPIN-1:0] analog_input_select,
    output logic      [sbp_pkg::NPIN-1:0] pin_change
);
    import sbp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Storage
    ////////////////////////////////////////////////////////////////////
    logic [NPIN-1:0] output_latch_q;       // Output latch
    logic [NPIN-1:0] output_latch_d;       // Next latch value
    logic [NPIN-1:0] pin_direction_q;      // One means input
    logic [NPIN-1:0] open_drain_q;         // Sink-only select
    logic [NPIN-1:0] slew_q;               // Slew limit select
    logic [NPIN-1:0] thr_q;                // Threshold select
    logic [NPIN-1:0] ana_q;                // Analog select
    logic [NPIN-1:0] sync1_q;              // Synchroniser stage one
    logic [NPIN-1:0] sync2_q;              // Synchroniser stage two
    logic [NPIN-1:0] prev_q;               // Last synchronised level
    logic [31:0]     prdata_q;             // Captured read data

    ////////////////////////////////////////////////////////////////////
    // Decode
    ////////////////////////////////////////////////////////////////////
    // Offset match
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] off);
        hit = (a == off);
    endfunction

    logic sel_data;                        // Data register hit
    logic sel_lat;                         // Latch register hit
    logic sel_dir;                         // Direction hit
    logic sel_od;                          // Open-drain hit
    logic sel_slew;                        // Slew hit
    logic sel_thr;                         // Threshold hit
    logic sel_ana;                         // Analog hit
    logic mapped;                          // Any register hit
    logic setup;                           // APB setup phase
    logic wr;                              // Write takes effect
    logic wr_lane;                         // Low byte lane written
    logic [NPIN-1:0] wbits;                // Written pin bits
    logic [NPIN-1:0] pin_read;             // Digital pin view
    logic [NPIN-1:0] dir_read;             // Direction readback
    logic [31:0]     rd_mux;               // Selected read word

    assign sel_data = hit(paddr, OFF_DATA);
    assign sel_lat  = hit(paddr, OFF_LAT);
    assign sel_dir  = hit(paddr, OFF_DIR);
    assign sel_od   = hit(paddr, OFF_OD);
    assign sel_slew = hit(paddr, OFF_SLEW);
    assign sel_thr  = hit(paddr, OFF_THR);
    assign sel_ana  = hit(paddr, OFF_ANA);
    assign mapped   = sel_data | sel_lat | sel_dir | sel_od |
                      sel_slew | sel_thr | sel_ana;
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite & mapped;
    assign wr_lane  = pstrb[0];
    assign wbits    = pwdata[NPIN-1:0];

    // Zero-wait slave, error on unmapped access
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_q;

    ////////////////////////////////////////////////////////////////////
    // Read path
    ////////////////////////////////////////////////////////////////////
    // analog pins read zero
    assign pin_read = sync2_q & ~ana_q;
    assign dir_read = pin_direction_q | IN_ONLY_MASK;

    assign rd_mux = sel_data ? {RD_PAD, pin_read} :
                    sel_lat  ? {RD_PAD, output_latch_q} :
                    sel_dir  ? {RD_PAD, dir_read} :
                    sel_od   ? {RD_PAD, open_drain_q} :
                    sel_slew ? {RD_PAD, slew_q} :
                    sel_thr  ? {RD_PAD, thr_q} :
                    sel_ana  ? {RD_PAD, ana_q} : 32'h0;

    // Read data captured in setup, held through access
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Synchroniser
    ////////////////////////////////////////////////////////////////////
    // two flops before any reader
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= RST_LAT;
            sync2_q <= RST_LAT;
            prev_q  <= RST_LAT;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Change pulse on the digital view
    assign pin_change = (sync2_q ^ prev_q) & ~ana_q;

    ////////////////////////////////////////////////////////////////////
    // Output latch
    ////////////////////////////////////////////////////////////////////
    // data write takes written bits if low lane strobed, else sampled pins; latch write needs the strobe
    assign output_latch_d = (sel_data & wr) ?
                            (wr_lane ? wbits : pin_read) :
                            (sel_lat & wr & wr_lane) ? wbits :
                            output_latch_q;

    // Latch update
    always_ff @(posedge clk) begin
        if (srst) begin
            output_latch_q <= RST_LAT;
        end else begin
            output_latch_q <= output_latch_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    ////////////////////////////////////////////////////////////////////
    // reset to input and analog
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_direction_q <= RST_DIR;
            open_drain_q    <= RST_OD;
            slew_q          <= RST_SLEW;
            thr_q           <= RST_THR;
            ana_q           <= RST_ANA;
        end else if (wr & wr_lane) begin
            if (sel_dir) begin
                pin_direction_q <= wbits | IN_ONLY_MASK;
            end
            if (sel_od) begin
                open_drain_q <= wbits;
            end
            if (sel_slew) begin
                slew_q <= wbits;
            end
            if (sel_thr) begin
                thr_q <= wbits;
            end
            if (sel_ana) begin
                ana_q <= wbits;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pad drivers
    ////////////////////////////////////////////////////////////////////
    logic [NPIN-1:0] drive;                // Driver enabled by direction

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pad
            if (g == IN_ONLY) begin : g_in
                assign drive[g]   = 1'b0;
                assign pin_out[g] = 1'b0;
                assign pin_oe[g]  = 1'b0;
            end else begin : g_io
                assign drive[g] = ~pin_direction_q[g];
                assign pin_out[g] = open_drain_q[g] ? 1'b0 :
                                    output_latch_q[g];
                assign pin_oe[g]  = drive[g] &
                                    (~open_drain_q[g] |
                                     ~output_latch_q[g]);
            end
        end
    endgenerate

    assign slew_limit_select      = slew_q;
    assign input_threshold_select = thr_q;
    assign analog_input_select    = ana_q;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_dir_gate;
        (pin_oe & pin_direction_q) == RST_LAT;
    endproperty
    a_dir_gate: assert property (p_dir_gate)
        else $error("driver on while input");

    property p_in_only;
        pin_oe[IN_ONLY] == 1'b0 && dir_read[IN_ONLY] == 1'b1;
    endproperty
    a_in_only: assert property (p_in_only)
        else $error("input-only pin misbehaves");

    property p_data_read;
        (setup && !pwrite && sel_data) |=>
            prdata[NPIN-1:0] == $past(pin_read);
    endproperty
    a_data_read: assert property (p_data_read)
        else $error("data read not pin state");

    property p_rmw;
        (wr && sel_data && !wr_lane) |=>
            output_latch_q == $past(sync2_q & ~ana_q);
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("rmw latch wrong");

    property p_data_wr;
        (wr && sel_data && wr_lane) |=>
            output_latch_q == $past(wbits);
    endproperty
    a_data_wr: assert property (p_data_wr)
        else $error("data write missed latch");

    property p_ana_zero;
        (setup && !pwrite && sel_data) |=>
            (prdata[NPIN-1:0] & $past(ana_q)) == RST_LAT;
    endproperty
    a_ana_zero: assert property (p_ana_zero)
        else $error("analog pin read nonzero");

    property p_od;
        (pin_oe & open_drain_q & pin_out) == RST_LAT;
    endproperty
    a_od: assert property (p_od)
        else $error("open drain sourced");

    property p_slew;
        (wr && wr_lane && sel_slew) |=>
            slew_limit_select == $past(wbits);
    endproperty
    a_slew: assert property (p_slew)
        else $error("slew select not written");

    property p_thr;
        (wr && wr_lane && sel_thr) |=>
            input_threshold_select == $past(wbits);
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold select not written");

    property p_ana_drive;
        (ana_q[0] && ~pin_direction_q[0] && ~open_drain_q[0]) |->
            pin_oe[0] && pin_out[0] == output_latch_q[0];
    endproperty
    a_ana_drive: assert property (p_ana_drive)
        else $error("output blocked");

    property p_sync;
        !$past(srst, 2) |-> sync2_q == $past(pin_in, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchroniser depth wrong");

    property p_reset;
        disable iff (1'b0)
        srst |=> pin_direction_q == RST_DIR && ana_q == RST_ANA &&
                 pin_oe == RST_LAT;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");

    // direction write lands, bit three kept
    property p_dir_wr;
        (wr && wr_lane && sel_dir) |=>
            pin_direction_q == ($past(wbits) | IN_ONLY_MASK);
    endproperty
    a_dir_wr: assert property (p_dir_wr)
        else $error("direction write lost");

    property p_in_only_q;
        pin_direction_q[IN_ONLY] == 1'b1;
    endproperty
    a_in_only_q: assert property (p_in_only_q)
        else $error("input-only direction cleared");

    property p_lat_keep;
        (psel && penable && !pwrite) |=> $stable(output_latch_q);
    endproperty
    a_lat_keep: assert property (p_lat_keep)
        else $error("read disturbed latch");

    property p_od_wr;
        (wr && wr_lane && sel_od) |=> open_drain_q == $past(wbits);
    endproperty
    a_od_wr: assert property (p_od_wr)
        else $error("open-drain write lost");

    property p_ana_wr;
        (wr && wr_lane && sel_ana) |=>
            analog_input_select == $past(wbits);
    endproperty
    a_ana_wr: assert property (p_ana_wr)
        else $error("analog select write lost");

    property p_chg_ana;
        (pin_change & analog_input_select) == '0;
    endproperty
    a_chg_ana: assert property (p_chg_ana)
        else $error("change pulse on analog pin");

    // change follows pins two clocks late
    property p_chg_src;
        (!$past(srst) && !$past(srst, 2) && !$past(srst, 3)) |->
            pin_change == (($past(pin_in, 2) ^ $past(pin_in, 3)) & ~ana_q);
    endproperty
    a_chg_src: assert property (p_chg_src)
        else $error("change pulse out of step");
endmodule

/* File: tb/sbp_pin_model.sv */
////////////////////////////////////////////////////////////////////////
// Pad model: board circuit with a pull-up on every pin
module sbp_pin_model (
    input  wire logic [sbp_pkg::NPIN-1:0] pin_out,
    input  wire logic [sbp_pkg::NPIN-1:0] pin_oe,
    input  wire logic [sbp_pkg::NPIN-1:0] ext_en,
    input  wire logic [sbp_pkg::NPIN-1:0] ext_val,
    output logic      [sbp_pkg::NPIN-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbp_pkg::*;
    // Wire level: port driver wins, else source, else pull-up
    // sink-only drive
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~(ext_en & ~ext_val));
endmodule

/* File: tb/testbench.sv */
////////////////////////////////////////////////////////////////////////
// Self-checking bench over APB
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbp_pkg::*;
    logic            clk, srst, psel, penable, pwrite;
    logic [AW-1:0]   paddr;
    logic [31:0]     pwdata, prdata;
    logic [3:0]      pstrb;
    logic            pready, pslverr;
    logic [NPIN-1:0] pin_in, pin_out, pin_oe, slew, thr, ana, chg;
    logic [NPIN-1:0] ext_en, ext_val;
    int              miscompares, tests_run;
    // Clock, 8 ns period
    always #4 clk = ~clk;
    sbp_port uut (
        .clk                    (clk),
        .srst                   (srst),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .pstrb                  (pstrb),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .pin_in                 (pin_in),
        .pin_out                (pin_out),
        .pin_oe                 (pin_oe),
        .slew_limit_select      (slew),
        .input_threshold_select (thr),
        .analog_input_select    (ana),
        .pin_change             (chg)
    );
    sbp_pin_model pads (
        .pin_out (pin_out),
        .pin_oe  (pin_oe),
        .ext_en  (ext_en),
        .ext_val (ext_val),
        .pin_in  (pin_in)
    );
    ////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Compare seen against expected
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, idle edge after release
    task automatic apb(input logic w, input logic [AW-1:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Register write, full strobe unless given
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, s, r, e);
    endtask
    // Register read with expected data and error flag
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp,
                      input logic experr = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, experr});
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; pstrb = '0;
        ext_en = 6'h3f; ext_val = 6'h2a;
        miscompares = 0; tests_run = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check({26'h0, pin_oe}, 32'h0); // no drive after reset
        rd(OFF_DIR, 32'h3f);
        rd(OFF_ANA, 32'h3f);
        rd(OFF_LAT, 32'h0);
        rd(OFF_OD, 32'h0);
        rd(OFF_SLEW, 32'h0);
        rd(OFF_THR, 32'h0);
        rd(OFF_DATA, 32'h0); // analog pins read zero
        wr(OFF_ANA, 32'h0);
        check({26'h0, ana}, 32'h0);
        repeat (3) @(posedge clk);
        rd(OFF_DATA, 32'h2a); // pin state seen
        wr(OFF_DIR, 32'h0);
        rd(OFF_DIR, 32'h08); // input-only bit reads one
        wr(OFF_DATA, 32'h15);
        rd(OFF_LAT, 32'h15); // write lands in latch
        check({26'h0, pin_oe}, 32'h37);
        check({26'h0, pin_out & 6'h37}, 32'h15);
        wr(OFF_ANA, 32'h03);
        repeat (3) @(posedge clk);
        rd(OFF_DATA, 32'h1c);
        check({26'h0, pin_oe}, 32'h37); // analog keeps drive
        wr(OFF_DATA, 32'hff, 4'h0);
        rd(OFF_LAT, 32'h1c); // read-modify-write result
        wr(OFF_OD, 32'h3f);
        check({26'h0, pin_oe}, 32'h23); // sink only
        check({26'h0, pin_out}, 32'h0);
        repeat (3) @(posedge clk);
        rd(OFF_DATA, 32'h08); // only bit three high, bits two and four sunk by source
        wr(OFF_SLEW, 32'h2a);
        check({26'h0, slew}, 32'h2a);
        wr(OFF_THR, 32'h15);
        check({26'h0, thr}, 32'h15);
        rd(OFF_THR, 32'h15);
        wr(OFF_DIR, 32'h3f);
        check({26'h0, pin_oe}, 32'h0); // all pins set to input, none driven
        // Change pulse on digital inputs, then masked when analog
        wr(OFF_ANA, 32'h0);
        repeat (3) @(posedge clk);
        ext_val <= 6'h15;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({26'h0, chg}, 32'h3f); // change after two flops
        @(negedge clk);
        check({26'h0, chg}, 32'h0); // one-cycle pulse
        @(posedge clk);
        wr(OFF_ANA, 32'h3f);
        ext_val <= 6'h2a;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({26'h0, chg}, 32'h0); // analog pins masked
        @(posedge clk);
        rd(5'h1c, 32'h0, 1'b1);
        finish_test();
    end
endmodule
